// *** bench/sss_adc_model.sv ***
// behavioural converter answering the scan logic
// result is {channel, 7'h35}; data lines churn outside the done strobe
`timescale 1ns/10ps

module sss_adc_model #(
	parameter int LAT = 5
) (
	input  wire logic       clock,
	input  wire logic       nrst,
	input  wire logic       adc_start,
	input  wire logic [2:0] adc_ch,
	output logic            adc_done,
	output logic      [9:0] adc_data
);
	int cnt;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cnt <= 0;
			adc_done <= 1'b0;
			adc_data <= 10'h3FF;
		end else begin
			adc_done <= 1'b0;
			adc_data <= ~adc_data;
			if (adc_start) begin
				cnt <= LAT;
			end else if (cnt == 1) begin
				adc_done <= 1'b1;
				adc_data <= {adc_ch, 7'h35};
				cnt <= 0;
			end else if (cnt != 0) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule

// *** bench/sss_top_bench.sv ***
// self-checking bench of sss_top with a shortened tick
// drives the avalon bus and all inputs; converter is sss_adc_model
`timescale 1ns/10ps

module sss_top_bench;
	localparam int T   = 4;
	localparam int D1  = 1_562_500 / 12_500 * T;
	localparam int D25 = 25_000_000 / 12_500 * T;
	localparam int D50 = 50_000_000 / 12_500 * T;
	localparam int WD  = 6_250_000 / 12_500 * T;
	localparam logic [9:0] R0 = {3'h0, 7'h35};
	typedef struct packed {
		logic [31:0] cfg;
		logic [5:0]  pri;
		logic [5:0]  sec;
		logic [3:0]  gpi;
		logic        mr_n;
		logic        exp;
	} sss_row_t;
	// output 0 cause, inputs, expected pin 0
	sss_row_t rows [8] = '{
		'{32'h0000_0001, 6'h3E, 6'h3F, 4'h0, 1'b1, 1'b0},
		'{32'h0000_0001, 6'h3F, 6'h3F, 4'h0, 1'b1, 1'b1},
		'{32'h0000_0040, 6'h3F, 6'h3F, 4'h0, 1'b1, 1'b0},
		'{32'h0000_0040, 6'h3F, 6'h3E, 4'h0, 1'b1, 1'b1},
		'{32'h4000_1000, 6'h3F, 6'h3E, 4'h1, 1'b1, 1'b1},
		'{32'h4000_1000, 6'h3F, 6'h3E, 4'h0, 1'b1, 1'b0},
		'{32'h0004_0000, 6'h3F, 6'h3E, 4'h0, 1'b0, 1'b0},
		'{32'h0004_0000, 6'h3F, 6'h3E, 4'h0, 1'b1, 1'b1}};
	logic        clock;
	logic        nrst;
	logic [9:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic        waitrequest;
	logic [95:0] thr_code;
	logic [5:0]  sec_overvoltage;
	logic [5:0]  range_narrow;
	logic [5:0]  det_pri_above;
	logic [5:0]  det_sec_above;
	logic [3:0]  general_logic_inputs;
	logic        manual_reset_input_n;
	logic        margin_n;
	logic        supply_ok;
	logic [7:0]  programmable_output;
	logic        adc_start;
	logic [2:0]  adc_ch;
	logic        adc_done;
	logic [9:0]  adc_data;
	logic [31:0] d;
	logic        s;
	logic        acc;
	logic [95:0] thr_e;
	int          err_count;
	int          checked;

	sss_top #(.TICK_CYC(12'h004)) sss_top_i (.clock(clock), .nrst(nrst),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
		.det_pri_above(det_pri_above), .det_sec_above(det_sec_above),
		.thr_code(thr_code), .sec_overvoltage(sec_overvoltage), .range_narrow(range_narrow),
		.general_logic_inputs(general_logic_inputs), .manual_reset_input_n(manual_reset_input_n),
		.margin_n(margin_n), .supply_ok(supply_ok), .programmable_output(programmable_output),
		.adc_start(adc_start), .adc_ch(adc_ch), .adc_done(adc_done), .adc_data(adc_data));
	sss_adc_model sss_adc_model_i (.clock(clock), .nrst(nrst), .adc_start(adc_start),
		.adc_ch(adc_ch), .adc_done(adc_done), .adc_data(adc_data));

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// ------------------------------------------------------------------
	// tasks: drivers start on a rising edge, checks sit at falling edges
	// ------------------------------------------------------------------
	task finish_test;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [95:0] e, input logic [95:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clock);
	endtask
	task ack_wait;
		int n;
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (waitrequest !== 1'b0 && n < 16);
		if (waitrequest !== 1'b0) begin
			err_count++;
			finish_test();
		end
	endtask
	task bus_wr(input logic [7:0] idx, input logic [31:0] v);
		@(posedge clock);
		address <= {idx, 2'h0};
		writedata <= v;
		write <= 1'b1;
		ack_wait();
		@(posedge clock);
		write <= 1'b0;
	endtask
	task bus_rd(input logic [7:0] idx, output logic [31:0] v);
		@(posedge clock);
		address <= {idx, 2'h0};
		read <= 1'b1;
		ack_wait();
		v = readdata;
		@(posedge clock);
		read <= 1'b0;
	endtask
	task set_in(input logic [5:0] p, input logic [5:0] q, input logic [3:0] g, input logic m);
		@(posedge clock);
		det_pri_above <= p;
		det_sec_above <= q;
		general_logic_inputs <= g;
		manual_reset_input_n <= m;
	endtask
	task watch(input int n, output logic seen);
		seen = 1'b0;
		repeat (n) begin
			@(negedge clock);
			if (programmable_output[0] !== 1'b1) seen = 1'b1;
		end
	endtask

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		err_count = 0;
		checked = 0;
		{nrst, read, write, address, writedata} = '0;
		{det_pri_above, det_sec_above} = 12'hFFF;
		{general_logic_inputs, manual_reset_input_n, margin_n, supply_ok} = 7'h07;
		repeat (5) @(posedge clock);
		nrst <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			bus_wr(8'(i), 32'(8'hA0 + i));
			thr_e[8*i +: 8] = 8'hA0 + 8'(i);
		end
		bus_wr(sss_pkg::REG_SECDIR, 32'h01);
		bus_wr(sss_pkg::REG_RANGE, 32'h2A);
		cyc(2);
		chk("thr_code", thr_e, thr_code);
		chk("range_narrow", 6'h2A, range_narrow);
		chk("sec_overvoltage", 6'h01, sec_overvoltage);
		bus_rd(8'h70, d);
		chk("unmapped", 0, d);
		for (int i = 0; i < 8; i++) begin
			set_in(rows[i].pri, rows[i].sec, rows[i].gpi, rows[i].mr_n);
			bus_wr(sss_pkg::REG_POCFG0, rows[i].cfg);
			cyc(40);
			chk("pins", {7'h7F, rows[i].exp}, programmable_output);
		end
		bus_wr(sss_pkg::REG_FLOG0, 32'h7FFFF);
		bus_wr(sss_pkg::REG_POCFG0, 32'h1800_0001);
		bus_wr(8'h24, 32'h1800_0001);
		set_in(6'h3E, 6'h3E, 4'h0, 1'b1);
		cyc(40);
		chk("pins", 8'hEE, programmable_output);
		set_in(6'h3F, 6'h3E, 4'h0, 1'b1);
		cyc(D25 - 4 * T);
		chk("pins", 8'hEE, programmable_output);
		cyc(8 * T);
		chk("pins", 8'hEF, programmable_output);
		cyc(D50 - D25);
		chk("pins", 8'hFF, programmable_output);
		bus_rd(sss_pkg::REG_FLOG0, d);
		chk("fault log", 32'h1, d);
		bus_wr(8'h24, 32'h0);
		bus_wr(sss_pkg::REG_POCFG0, 32'h0800_0001);
		set_in(6'h3E, 6'h3E, 4'h0, 1'b1);
		cyc(40);
		set_in(6'h3F, 6'h3E, 4'h0, 1'b1);
		cyc(D1 * 3 / 5);
		set_in(6'h3E, 6'h3E, 4'h0, 1'b1);
		cyc(20);
		set_in(6'h3F, 6'h3E, 4'h0, 1'b1);
		cyc(D1 * 9 / 10);
		chk("pins", 8'hFE, programmable_output);
		cyc(D1 / 5 + 4 * T);
		chk("pins", 8'hFF, programmable_output);
		bus_wr(sss_pkg::REG_POCFG0, 32'h8004_0001);
		@(posedge clock) margin_n <= 1'b0;
		set_in(6'h3E, 6'h3E, 4'h0, 1'b0);
		cyc(40);
		chk("pins", 8'hFF, programmable_output);
		@(posedge clock) margin_n <= 1'b1;
		cyc(40);
		chk("pins", 8'hFE, programmable_output);
		set_in(6'h3F, 6'h3E, 4'h0, 1'b1);
		cyc(40);
		chk("pins", 8'hFF, programmable_output);
		bus_wr(sss_pkg::REG_MISC, 32'h1F);
		@(posedge clock) margin_n <= 1'b0;
		cyc(8);
		chk("pins", 8'hFE, programmable_output);
		@(posedge clock) margin_n <= 1'b1;
		bus_wr(sss_pkg::REG_MISC, 32'h0E);
		bus_wr(sss_pkg::REG_POCFG0, 32'h4000_1000);
		cyc(40);
		chk("pins", 8'hFF, programmable_output);
		bus_wr(sss_pkg::REG_MISC, 32'h0F);
		cyc(40);
		chk("pins", 8'hFE, programmable_output);
		bus_wr(sss_pkg::REG_POCFG0, 32'h0001_0000);
		bus_wr(sss_pkg::REG_WDCFG0, 32'h0301);
		watch(WD - 100, s);
		chk("early expiry", 0, s);
		watch(500, s);
		chk("expiry", 1, s);
		bus_wr(sss_pkg::REG_WDCFG0, 32'h0101);
		acc = 1'b0;
		for (int i = 0; i < 6; i++) begin
			@(posedge clock) general_logic_inputs <= {3'h0, ~general_logic_inputs[0]};
			watch(WD / 4, s);
			acc |= s;
		end
		chk("cleared watchdog", 0, acc);
		bus_wr(sss_pkg::REG_WDCFG0, 32'h0);
		@(posedge clock) supply_ok <= 1'b0;
		cyc(3);
		chk("pins", 8'h00, programmable_output);
		@(posedge clock) supply_ok <= 1'b1;
		cyc(40);
		chk("pins", 8'hFF, programmable_output);
		bus_wr(sss_pkg::REG_ADC0, 32'hFF);
		bus_rd(sss_pkg::REG_ADC0, d);
		chk("scan high", {24'h0, R0[9:2]}, d);
		bus_rd(8'h51, d);
		chk("scan low", {24'h0, R0[1:0], 6'h0}, d);
		@(posedge clock) nrst <= 1'b0;
		cyc(2);
		chk("pins", 8'h00, programmable_output);
		chk("thr_code", 96'h0, thr_code);
		@(posedge clock) nrst <= 1'b1;
		bus_rd(sss_pkg::REG_MISC, d);
		chk("misc", 32'h0F, d);
		bus_rd(sss_pkg::REG_POCFG0, d);
		chk("config", 32'h0, d);
		finish_test();
	end
endmodule

// *** bench/sss_top_sva.sv ***
// assertions on the supervisor's bus, register copies, scan and pins
// sees only sss_top ports; bound in at the foot of this file
`timescale 1ns/10ps

module sss_top_chk (
	// clock and reset
	input wire logic        clock,
	input wire logic        nrst,
	// register bus
	input wire logic [9:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] writedata,
	input wire logic [3:0]  byteenable,
	input wire logic        waitrequest,
	// device side
	input wire logic [95:0] thr_code,
	input wire logic [5:0]  sec_overvoltage,
	input wire logic [5:0]  range_narrow,
	input wire logic        margin_n,
	input wire logic        supply_ok,
	input wire logic [7:0]  programmable_output,
	input wire logic        adc_start,
	input wire logic [2:0]  adc_ch
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// three quiet cycles: the frozen state has reached the pins
	sequence quiet_s;
		!margin_n && supply_ok && !write;
	endsequence
	sequence frozen_s;
		quiet_s [*3];
	endsequence
	write_no_wait_a: assert property (write |-> !waitrequest)
		else $error("write stalled");
	read_answer_a: assert property (read && waitrequest |=> !waitrequest)
		else $error("read answer late");
	thr_copy_a: assert property (write && byteenable[0] && address[9:2] <= 8'h0B |=>
		thr_code[{$past(address[5:2]), 3'h0} +: 8] == $past(writedata[7:0]))
		else $error("threshold byte not driven");
	sec_copy_a: assert property (write && byteenable[0] && address[9:2] == 8'h0C |=>
		sec_overvoltage == $past(writedata[5:0]))
		else $error("secondary direction not driven");
	range_copy_a: assert property (write && byteenable[0] && address[9:2] == 8'h0D |=>
		range_narrow == $past(writedata[5:0]))
		else $error("range select not driven");
	scan_pulse_a: assert property (adc_start |=> !adc_start [*8])
		else $error("start not a lone pulse");
	scan_step_a: assert property ($changed(adc_ch) |-> adc_ch == $past(adc_ch) + 3'h1)
		else $error("channel skipped");
	supply_lockout_a: assert property (!supply_ok [*2] |=> programmable_output == 8'h00)
		else $error("pins not cleared in lockout");
	margin_hold_a: assert property (frozen_s |-> $stable(programmable_output))
		else $error("pins moved while frozen");
endmodule

bind sss_top sss_top_chk sss_top_chk_i (
	.clock(clock), .nrst(nrst), .address(address), .read(read), .write(write),
	.writedata(writedata), .byteenable(byteenable), .waitrequest(waitrequest),
	.thr_code(thr_code), .sec_overvoltage(sec_overvoltage), .range_narrow(range_narrow),
	.margin_n(margin_n), .supply_ok(supply_ok), .programmable_output(programmable_output),
	.adc_start(adc_start), .adc_ch(adc_ch)
);

// *** inc/sss_pkg.sv ***
// constants, tables and state types of the supply sequencer and supervisor
// assumes a 250 MHz clock and an avalon-mm register bus addressed in bytes

package sss_pkg;

	// ------------------------------------------------------------------
	// sizes and timing
	// ------------------------------------------------------------------
	localparam int NUM_DET = 6;
	localparam int NUM_PO  = 8;
	localparam int NUM_GPI = 4;
	localparam int NUM_ADC = 8;

	localparam longint unsigned CLK_NS  = 4;
	// 12.5us divides every output and watchdog period exactly
	localparam longint unsigned TICK_NS = 12500;
	localparam logic [11:0]     TICK_CYC = 12'(TICK_NS / CLK_NS);

	localparam longint unsigned ADC_SCAN_NS    = 200_000_000;
	localparam logic [10:0]     ADC_SLOT_TICKS = 11'(ADC_SCAN_NS / NUM_ADC / TICK_NS);

	localparam longint unsigned PO_DLY_G1_NS [8] = '{25_000, 1_562_500, 6_250_000,
		25_000_000, 50_000_000, 200_000_000, 400_000_000, 1_600_000_000};
	// second group has no 25ms step; code 7 repeats the longest delay
	localparam longint unsigned PO_DLY_G2_NS [8] = '{25_000, 1_562_500, 6_250_000,
		50_000_000, 200_000_000, 400_000_000, 1_600_000_000, 1_600_000_000};
	localparam longint unsigned WD_TMO_NS [8] = '{6_250_000, 25_000_000, 100_000_000,
		400_000_000, 1_600_000_000, 6_400_000_000, 25_600_000_000, 102_400_000_000};

	// ------------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ------------------------------------------------------------------
	localparam logic [7:0] REG_THR0     = 8'h00;
	localparam logic [7:0] REG_THR_LAST = 8'h0B;
	localparam logic [7:0] REG_SECDIR   = 8'h0C;
	localparam logic [7:0] REG_RANGE    = 8'h0D;
	localparam logic [7:0] REG_POCFG0   = 8'h20;
	localparam logic [7:0] REG_MISC     = 8'h30;
	localparam logic [7:0] REG_WDCFG0   = 8'h31;
	localparam logic [7:0] REG_FLOG0    = 8'h40;
	localparam logic [7:0] REG_STATUS   = 8'h48;
	localparam logic [7:0] REG_ADC0     = 8'h50;
	localparam logic [7:0] REG_ADC_LAST = 8'h5F;

	// output configuration word; fault log uses the same low 19 bits
	localparam int POC_DET_LSB = 0;
	localparam int POC_GPI_LSB = 12;
	localparam int POC_WD_LSB  = 16;
	localparam int POC_MR      = 18;
	localparam int POC_PO_LSB  = 19;
	localparam int POC_DLY_LSB = 27;
	localparam int POC_AH      = 30;
	localparam int POC_MRG     = 31;
	localparam int MISC_MRG_DRIVE = 4;

	// watchdog configuration word
	localparam int WDC_EN       = 0;
	localparam int WDC_INIT_EN  = 1;
	localparam int WDC_INIT_LSB = 2;
	localparam int WDC_NORM_LSB = 5;
	localparam int WDC_MODE_LSB = 8;
	localparam int WDC_GPI_LSB  = 10;
	localparam int WDC_PO_LSB   = 12;
	localparam logic [1:0] WD_CLR_BOTH = 2'h0;
	localparam logic [1:0] WD_CLR_GPI  = 2'h1;
	localparam logic [1:0] WD_CLR_PO   = 2'h2;

	localparam logic [31:0] POCFG_RST = 32'h0000_0000;
	localparam logic [4:0]  MISC_RST  = 5'h0F;

	// ------------------------------------------------------------------
	// state types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {WD_OFF, WD_INIT, WD_RUN} sss_wd_t;
	typedef enum logic {ADC_WAIT, ADC_CONV} sss_adc_t;

	typedef struct packed {
		logic [11:0]                det_s1;
		logic [11:0]                det_s2;
		logic [11:0][7:0]           thr;
		logic [5:0]                 sec_ov;
		logic [5:0]                 rng;
		logic [NUM_PO-1:0][31:0]    po_cfg;
		logic [4:0]                 misc;
		logic [1:0][14:0]           wd_cfg;
		logic [NUM_PO-1:0][18:0]    flog;
		logic [NUM_PO-1:0]          po_act;
		logic [NUM_PO-1:0]          po_q;
		logic [NUM_PO-1:0]          po_pin;
		logic [NUM_PO-1:0][16:0]    dly_cnt;
		logic [11:0]                tick_cnt;
		logic                       tick;
		sss_wd_t [1:0]              wd_st;
		logic [1:0][22:0]           wd_cnt;
		logic [1:0]                 wd_exp;
		logic [NUM_GPI-1:0]         gpi_q;
		sss_adc_t                   adc_st;
		logic [2:0]                 adc_ch;
		logic [10:0]                slot_cnt;
		logic                       adc_start;
		logic                       rd_ack;
		logic                       rd_adc;
		logic                       rd_lo;
		logic [31:0]                rdata;
	} sss_state_t;

endpackage

// *** rtl/sss_adc_mem.sv ***
// result store of the converter scan
// one write port from the scan logic, one registered read port for the bus
`timescale 1ns/10ps

module sss_adc_mem #(
	parameter int W  = 10,
	parameter int D  = 8,
	parameter int AW = 3
) (
	// clock and reset
	input  wire logic          clock,
	input  wire logic          nrst,
	// write side
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	// read side
	input  wire logic [AW-1:0] raddr,
	output logic      [W-1:0]  rdata
);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [W-1:0]        rdata;
	} sss_mem_state_t;

	sss_mem_state_t st_r;
	sss_mem_state_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		// read sees the old word when both ports hit the same entry
		st_nxt.rdata = st_r.mem[raddr];
		if (we) begin
			st_nxt.mem[waddr] = wdata;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata = st_r.rdata;

endmodule

// *** rtl/sss_top.sv ***
// supervisor and sequencer logic: detectors, outputs, watchdogs, scan, registers
// comparators, converter and output drivers are analog and sit outside;
// gpi, manual reset, margin and supply_ok are synchronous to clock
`timescale 1ns/10ps

module sss_top #(
	parameter logic [11:0] TICK_CYC = sss_pkg::TICK_CYC
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        nrst,
	// avalon-mm slave
	input  wire logic [9:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// detector comparators and their settings
	input  wire logic [5:0]  det_pri_above,
	input  wire logic [5:0]  det_sec_above,
	output logic      [95:0] thr_code,
	output logic      [5:0]  sec_overvoltage,
	output logic      [5:0]  range_narrow,
	// logic inputs and supply
	input  wire logic [3:0]  general_logic_inputs,
	input  wire logic        manual_reset_input_n,
	input  wire logic        margin_n,
	input  wire logic        supply_ok,
	// programmable output pins
	output logic      [7:0]  programmable_output,
	// converter
	output logic             adc_start,
	output logic      [2:0]  adc_ch,
	input  wire logic        adc_done,
	input  wire logic [9:0]  adc_data
);

	sss_pkg::sss_state_t st_r;
	sss_pkg::sss_state_t st_nxt;

	logic [9:0] mem_rdata;
	logic       mem_we;
	logic [2:0] mem_raddr;
	logic [7:0] idx;

	assign idx       = address[9:2];
	assign mem_raddr = idx[3:1];
	assign mem_we    = (st_r.adc_st == sss_pkg::ADC_CONV) && adc_done;

	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	// ------------------------------------------------------------------
	// result store
	// ------------------------------------------------------------------
	sss_adc_mem #(
		.W  (10),
		.D  (sss_pkg::NUM_ADC),
		.AW (3)
	) u_mem (
		.clock (clock),
		.nrst  (nrst),
		.we    (mem_we),
		.waddr (st_r.adc_ch),
		.wdata (adc_data),
		.raddr (mem_raddr),
		.rdata (mem_rdata)
	);

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		logic [11:0] det_fault;
		logic [3:0]  gpi_act;
		logic        mr_act;
		logic        margin_act;
		logic [31:0] bm;
		logic [31:0] cfg;
		logic [14:0] wc;
		logic [18:0] cause;
		logic        cond;
		logic        clr;
		logic [22:0] lim;
		logic [16:0] dly;
		logic [7:0]  pmask;
		st_nxt     = st_r;
		det_fault  = '0;
		gpi_act    = '0;
		mr_act     = 1'b0;
		margin_act = 1'b0;
		bm         = '0;
		cfg        = '0;
		wc         = '0;
		cause      = '0;
		cond       = 1'b0;
		clr        = 1'b0;
		lim        = '0;
		dly        = '0;
		pmask      = '0;

		// time base shared by all delays, watchdogs and the scan
		if (st_r.tick_cnt >= TICK_CYC - 12'h001) begin
			st_nxt.tick_cnt = '0;
			st_nxt.tick     = 1'b1;
		end else begin
			st_nxt.tick_cnt = st_r.tick_cnt + 12'h001;
			st_nxt.tick     = 1'b0;
		end

		// two-stage synchroniser on the comparators
		st_nxt.det_s1 = {det_sec_above, det_pri_above};
		st_nxt.det_s2 = st_r.det_s1;
		for (int j = 0; j < sss_pkg::NUM_DET; j++) begin
			det_fault[j]     = ~st_r.det_s2[j];
			det_fault[6 + j] = st_r.sec_ov[j] ? st_r.det_s2[6 + j] : ~st_r.det_s2[6 + j];
		end
		gpi_act    = ~(general_logic_inputs ^ st_r.misc[3:0]);
		mr_act     = ~manual_reset_input_n;
		margin_act = ~margin_n;
		st_nxt.gpi_q = gpi_act;
		st_nxt.po_q  = st_r.po_act;

		// ------------------------------------------------------------------
		// register writes (fault-log clears come before the set below)
		// ------------------------------------------------------------------
		bm = lane_mask(byteenable);
		if (write) begin
			if (idx <= sss_pkg::REG_THR_LAST) begin
				st_nxt.thr[idx[3:0]] = (st_r.thr[idx[3:0]] & ~bm[7:0]) | (writedata[7:0] & bm[7:0]);
			end else if (idx == sss_pkg::REG_SECDIR) begin
				st_nxt.sec_ov = (st_r.sec_ov & ~bm[5:0]) | (writedata[5:0] & bm[5:0]);
			end else if (idx == sss_pkg::REG_RANGE) begin
				st_nxt.rng = (st_r.rng & ~bm[5:0]) | (writedata[5:0] & bm[5:0]);
			end else if (idx[7:3] == sss_pkg::REG_POCFG0[7:3]) begin
				st_nxt.po_cfg[idx[2:0]] = (st_r.po_cfg[idx[2:0]] & ~bm) | (writedata & bm);
			end else if (idx == sss_pkg::REG_MISC) begin
				st_nxt.misc = (st_r.misc & ~bm[4:0]) | (writedata[4:0] & bm[4:0]);
			end else if (idx == sss_pkg::REG_WDCFG0 || idx == sss_pkg::REG_WDCFG0 + 8'h01) begin
				st_nxt.wd_cfg[idx[1]] = (st_r.wd_cfg[idx[1]] & ~bm[14:0])
					| (writedata[14:0] & bm[14:0]);
			end else if (idx[7:3] == sss_pkg::REG_FLOG0[7:3]) begin
				st_nxt.flog[idx[2:0]] = st_r.flog[idx[2:0]] & ~(writedata[18:0] & bm[18:0]);
			end
		end

		// ------------------------------------------------------------------
		// watchdogs
		// ------------------------------------------------------------------
		for (int w = 0; w < 2; w++) begin
			wc = st_r.wd_cfg[w];
			st_nxt.wd_exp[w] = 1'b0;
			case (wc[sss_pkg::WDC_MODE_LSB +: 2])
				sss_pkg::WD_CLR_BOTH: clr =
					(gpi_act[wc[sss_pkg::WDC_GPI_LSB +: 2]] ^ st_r.gpi_q[wc[sss_pkg::WDC_GPI_LSB +: 2]])
					| (st_r.po_act[wc[sss_pkg::WDC_PO_LSB +: 3]] ^ st_r.po_q[wc[sss_pkg::WDC_PO_LSB +: 3]]);
				sss_pkg::WD_CLR_GPI: clr =
					gpi_act[wc[sss_pkg::WDC_GPI_LSB +: 2]] ^ st_r.gpi_q[wc[sss_pkg::WDC_GPI_LSB +: 2]];
				sss_pkg::WD_CLR_PO: clr =
					st_r.po_act[wc[sss_pkg::WDC_PO_LSB +: 3]] ^ st_r.po_q[wc[sss_pkg::WDC_PO_LSB +: 3]];
				default: clr = 1'b0;
			endcase
			if (st_r.wd_st[w] == sss_pkg::WD_INIT) begin
				lim = 23'(sss_pkg::WD_TMO_NS[wc[sss_pkg::WDC_INIT_LSB +: 3]] / sss_pkg::TICK_NS);
			end else begin
				lim = 23'(sss_pkg::WD_TMO_NS[wc[sss_pkg::WDC_NORM_LSB +: 3]] / sss_pkg::TICK_NS);
			end
			case (st_r.wd_st[w])
				sss_pkg::WD_OFF: begin
					st_nxt.wd_cnt[w] = '0;
					if (wc[sss_pkg::WDC_EN]) begin
						st_nxt.wd_st[w] = wc[sss_pkg::WDC_INIT_EN] ? sss_pkg::WD_INIT : sss_pkg::WD_RUN;
					end
				end
				sss_pkg::WD_INIT, sss_pkg::WD_RUN: begin
					if (!wc[sss_pkg::WDC_EN]) begin
						st_nxt.wd_st[w] = sss_pkg::WD_OFF;
					end else if (clr) begin
						st_nxt.wd_cnt[w] = '0;
						st_nxt.wd_st[w]  = sss_pkg::WD_RUN;
					end else if (st_r.tick) begin
						if (st_r.wd_cnt[w] >= lim - 23'h000001) begin
							st_nxt.wd_exp[w] = 1'b1;
							st_nxt.wd_cnt[w] = '0;
							st_nxt.wd_st[w]  = sss_pkg::WD_RUN;
						end else begin
							st_nxt.wd_cnt[w] = st_r.wd_cnt[w] + 23'h000001;
						end
					end
				end
				default: st_nxt.wd_st[w] = sss_pkg::WD_OFF;
			endcase
		end

		// ------------------------------------------------------------------
		// programmable outputs; detector, input and timer state and the linked outputs feed them
		// ------------------------------------------------------------------
		for (int i = 0; i < sss_pkg::NUM_PO; i++) begin
			cfg   = st_r.po_cfg[i];
			pmask = cfg[sss_pkg::POC_PO_LSB +: 8];
			pmask[i] = 1'b0;
			cause = {mr_act & cfg[sss_pkg::POC_MR],
				st_r.wd_exp & cfg[sss_pkg::POC_WD_LSB +: 2],
				gpi_act & cfg[sss_pkg::POC_GPI_LSB +: 4],
				det_fault & cfg[sss_pkg::POC_DET_LSB +: 12]};
			cond  = (|cause) | (|(st_r.po_act & pmask));
			if (i < 4) begin
				dly = 17'(sss_pkg::PO_DLY_G1_NS[cfg[sss_pkg::POC_DLY_LSB +: 3]] / sss_pkg::TICK_NS);
			end else begin
				dly = 17'(sss_pkg::PO_DLY_G2_NS[cfg[sss_pkg::POC_DLY_LSB +: 3]] / sss_pkg::TICK_NS);
			end
			if (!supply_ok) begin
				st_nxt.po_act[i]  = 1'b0;
				st_nxt.dly_cnt[i] = '0;
			end else if (margin_act) begin
				// margin wins over manual reset and every monitored input
				st_nxt.dly_cnt[i] = '0;
				if (st_r.misc[sss_pkg::MISC_MRG_DRIVE]) begin
					st_nxt.po_act[i] = cfg[sss_pkg::POC_MRG];
				end
			end else if (cond) begin
				st_nxt.po_act[i]  = 1'b1;
				st_nxt.dly_cnt[i] = '0;
				if (!st_r.po_act[i]) begin
					st_nxt.flog[i] = st_nxt.flog[i] | cause;
				end
			end else if (st_r.po_act[i] && st_r.tick) begin
				if (st_r.dly_cnt[i] >= dly - 17'h00001) begin
					st_nxt.po_act[i]  = 1'b0;
					st_nxt.dly_cnt[i] = '0;
				end else begin
					st_nxt.dly_cnt[i] = st_r.dly_cnt[i] + 17'h00001;
				end
			end
			st_nxt.po_pin[i] = supply_ok & ~(st_nxt.po_act[i] ^ cfg[sss_pkg::POC_AH]);
		end

		// ------------------------------------------------------------------
		// converter scan: one channel per slot, eight slots a pass
		// ------------------------------------------------------------------
		st_nxt.adc_start = 1'b0;
		if (st_r.tick) begin
			if (st_r.slot_cnt >= sss_pkg::ADC_SLOT_TICKS - 11'h001) begin
				st_nxt.slot_cnt = '0;
			end else begin
				st_nxt.slot_cnt = st_r.slot_cnt + 11'h001;
			end
		end
		case (st_r.adc_st)
			sss_pkg::ADC_WAIT: begin
				if (st_r.tick && st_r.slot_cnt == 11'h000) begin
					st_nxt.adc_start = 1'b1;
					st_nxt.adc_st    = sss_pkg::ADC_CONV;
				end
			end
			sss_pkg::ADC_CONV: begin
				if (adc_done) begin
					st_nxt.adc_ch = st_r.adc_ch + 3'h1;
					st_nxt.adc_st = sss_pkg::ADC_WAIT;
				end
			end
			default: st_nxt.adc_st = sss_pkg::ADC_WAIT;
		endcase

		// ------------------------------------------------------------------
		// register reads: one wait cycle, data captured at the request
		// ------------------------------------------------------------------
		st_nxt.rd_ack = read & ~st_r.rd_ack;
		if (read && !st_r.rd_ack) begin
			st_nxt.rd_adc = (idx >= sss_pkg::REG_ADC0) && (idx <= sss_pkg::REG_ADC_LAST);
			st_nxt.rd_lo  = idx[0];
			st_nxt.rdata  = '0;
			if (idx <= sss_pkg::REG_THR_LAST) begin
				st_nxt.rdata[7:0] = st_r.thr[idx[3:0]];
			end else if (idx == sss_pkg::REG_SECDIR) begin
				st_nxt.rdata[5:0] = st_r.sec_ov;
			end else if (idx == sss_pkg::REG_RANGE) begin
				st_nxt.rdata[5:0] = st_r.rng;
			end else if (idx[7:3] == sss_pkg::REG_POCFG0[7:3]) begin
				st_nxt.rdata = st_r.po_cfg[idx[2:0]];
			end else if (idx == sss_pkg::REG_MISC) begin
				st_nxt.rdata[4:0] = st_r.misc;
			end else if (idx == sss_pkg::REG_WDCFG0 || idx == sss_pkg::REG_WDCFG0 + 8'h01) begin
				st_nxt.rdata[14:0] = st_r.wd_cfg[idx[1]];
			end else if (idx[7:3] == sss_pkg::REG_FLOG0[7:3]) begin
				st_nxt.rdata[18:0] = st_r.flog[idx[2:0]];
			end else if (idx == sss_pkg::REG_STATUS) begin
				st_nxt.rdata[19:0] = {det_fault, st_r.po_act};
			end
		end
	end

	// ------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st_r        <= '0;
			st_r.misc   <= sss_pkg::MISC_RST;
			st_r.po_cfg <= {sss_pkg::NUM_PO{sss_pkg::POCFG_RST}};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign waitrequest = read & ~st_r.rd_ack;
	// results are split high byte then low bits, two registers a channel
	assign readdata = !st_r.rd_adc ? st_r.rdata
		: st_r.rd_lo ? {24'h000000, mem_rdata[1:0], 6'h00}
		: {24'h000000, mem_rdata[9:2]};
	assign thr_code            = st_r.thr;
	assign sec_overvoltage     = st_r.sec_ov;
	assign range_narrow        = st_r.rng;
	assign programmable_output = st_r.po_pin;
	assign adc_start           = st_r.adc_start;
	assign adc_ch              = st_r.adc_ch;

endmodule
